// ==== include/adc_flags_defs.svh ====
`ifndef ADC_FLAGS_DEFS_SVH
`define ADC_FLAGS_DEFS_SVH

// Register word offsets (byte addresses)
`define OFS_STATUS      4'h0
`define OFS_IRQ_ENABLE  4'h4
`define OFS_Q2_START    4'h8

// Status register bit positions
`define BIT_Q1_DONE     15
`define BIT_Q1_PAUSE    14
`define BIT_Q2_DONE     13
`define BIT_Q2_PAUSE    12
`define BIT_Q1_OVR      11
`define BIT_Q2_OVR      10

// Interrupt enable bit positions
`define EN_Q1_DONE      0
`define EN_Q1_PAUSE     1
`define EN_Q2_DONE      2
`define EN_Q2_PAUSE     3

// Command word table
`define LAST_LOCATION   6'd39
`define END_OF_QUEUE    6'd63

// Reset values
`define RST_IRQ_ENABLE  4'h0
`define RST_Q2_START    6'h28

`endif

// ==== include/adc_flags_pkg.sv ====
`default_nettype none
package adc_flags_pkg;
   // Queue-1 run state
   typedef enum logic [2:0] {
      Q1_IDLE   = 3'b001,
      Q1_ACTIVE = 3'b010,
      Q1_PAUSED = 3'b100
   } q1State_t;
   // Queue trigger source class
   typedef enum logic [1:0] {
      TRIG_SOFTWARE = 2'b01,
      TRIG_HARDWARE = 2'b10
   } trigSrc_t;
endpackage
`default_nettype wire

// ==== logic/adc_queue_status_flags.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "adc_flags_defs.svh"

//------------------------------------------------------------
// Register map
//------------------------------------------------------------
// Offset 0: status word, flags in bits 15:10, queue status 9:6,
//           command pointer 5:0; only the flags respond to writes
// Offset 4: interrupt enables, bit 0 queue-1 done, bit 1 queue-1 pause,
//           bit 2 queue-2 done, bit 3 queue-2 pause
// Offset 8: queue-2 start pointer, six bits
// Other offsets read as zero and ignore writes
//
// Flag vector index order, high to low:
//   5 queue-1 done, 4 queue-1 pause, 3 queue-2 done,
//   2 queue-2 pause, 1 queue-1 overrun, 0 queue-2 overrun
// The queue-2 overrun source sits outside this block, so index 0
// only ever reads back as zero here.

module adc_queue_status_flags
   import adc_flags_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Conversion engine: one-cycle pulse when a result is stored
   input  wire logic        resultStored,
   input  wire logic        resultQueue2,
   input  wire logic [5:0]  commandLocation,
   input  wire logic [5:0]  commandChannel,
   input  wire logic        commandPause,
   // Queue-1 trigger pulse and its source class
   input  wire logic        q1Trigger,
   input  wire logic        q1TriggerHardware,
   // Read-only status from the scheduler
   input  wire logic [3:0]  queueStatus,
   input  wire logic [5:0]  commandPointer,
   // Interrupt requests toward the level encoder
   output logic             q1IrqRequest,
   output logic             q2IrqRequest,
   output logic             q1Ended,
   output logic             q2Ended
);

   //------------------------------------------------------------
   // Bus decode
   //------------------------------------------------------------
   logic        busPhase_q;
   logic        accStatus;
   logic        rdStrobe;
   logic        wrStrobe;
   logic [5:0]  flags_q;
   logic [5:0]  readSeen_q;
   logic [3:0]  irqEnable_q;
   logic [5:0]  q2Start_q;
   q1State_t    q1State_q;
   logic [5:0]  setFlags;
   logic [5:0]  wrFlags;
   logic        lastQ1;
   logic        lastQ2;
   logic        accIrqEnable;
   logic        accQ2Start;
   logic        flagLane;
   logic [31:0] readMux;

   // Every access costs exactly one wait cycle: readdata is loaded on
   // the first edge and the strobes below fire on the second, so a
   // held request can never act twice. The price is a slower bus,
   // which a status block polled by software can easily afford.
   // One wait cycle per access so strobes act exactly once
   assign waitrequest = (read | write) & ~busPhase_q;
   assign rdStrobe    = read & busPhase_q;
   assign wrStrobe    = write & busPhase_q;
   assign accStatus   = (address == `OFS_STATUS);
   assign accIrqEnable = (address == `OFS_IRQ_ENABLE);
   assign accQ2Start   = (address == `OFS_Q2_START);
   // Flag clears need the byte lane that carries bits 15:8
   assign flagLane     = byteenable[1];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busPhase_q <= 1'b0;
      end else begin
         busPhase_q <= (read | write) & ~busPhase_q;
      end
   end

   //------------------------------------------------------------
   // End-of-queue detection
   //------------------------------------------------------------
   // The compare uses the pointer as it stands now, so a pointer moved
   // while queue 1 runs takes effect at the very next stored result.
   // The addition wraps in six bits, which is harmless: location 63
   // never occurs since the command table ends at location 39.
   // Queue 1 stops below the queue-2 start pointer, on the end code or at the table end
   assign lastQ1 = ((commandLocation + 6'd1) == q2Start_q)
                 | (commandChannel == `END_OF_QUEUE)
                 | (commandLocation == `LAST_LOCATION);
   // Queue 2 has no start-pointer boundary
   assign lastQ2 = (commandChannel == `END_OF_QUEUE)
                 | (commandLocation == `LAST_LOCATION);

   //------------------------------------------------------------
   // Flag set sources
   //------------------------------------------------------------
   // Set sources, one bit per flag in the index order above. A pause on
   // the last command sets both pause and done in the same cycle, and
   // both are set whatever the interrupt enables say, so software can
   // poll them.
   always_comb begin
      setFlags = 6'h00;
      if (resultStored && !resultQueue2) begin
         setFlags[5] = lastQ1;
         setFlags[4] = commandPause;
      end
      if (resultStored && resultQueue2) begin
         setFlags[3] = lastQ2;
         setFlags[2] = commandPause;
      end
      // Hardware trigger during an active scan is dropped and flagged
      setFlags[1] = q1Trigger && q1TriggerHardware
                  && (q1State_q == Q1_ACTIVE);
      setFlags[0] = 1'b0;  // Queue-2 overrun source lives elsewhere
   end

   // Writable flag bits pulled from the status word, byte lane 1 (bits 15:10)
   assign wrFlags = {writedata[`BIT_Q1_DONE], writedata[`BIT_Q1_PAUSE],
                     writedata[`BIT_Q2_DONE], writedata[`BIT_Q2_PAUSE],
                     writedata[`BIT_Q1_OVR],  writedata[`BIT_Q2_OVR]};

   //------------------------------------------------------------
   // Sticky flags with read-then-write-zero clear
   //------------------------------------------------------------
   // Each flag keeps its own read record. A set in the same cycle as an
   // armed clear wins and also drops the record, so software must read
   // the bit again before it can clear the new event. A result set on the
   // first edge of a read still arms the record at the accepting edge, though readdata missed it.
   genvar i;
   generate
      for (i = 0; i < 6; i++) begin : gFlag
         // Set beats a same-cycle clear so no event is lost
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               flags_q[i]    <= 1'b0;
               readSeen_q[i] <= 1'b0;
            end else if (setFlags[i]) begin
               flags_q[i]    <= 1'b1;
               readSeen_q[i] <= 1'b0;
            end else if (wrStrobe && accStatus && flagLane && readSeen_q[i]
                         && !wrFlags[i]) begin
               flags_q[i]    <= 1'b0;
               readSeen_q[i] <= 1'b0;
            end else if (rdStrobe && accStatus && flags_q[i]) begin
               readSeen_q[i] <= 1'b1;
            end
         end
      end
   endgenerate

   //------------------------------------------------------------
   // Queue-1 run state for overrun qualification
   //------------------------------------------------------------
   // Only the overrun logic needs this view of queue 1: a trigger from
   // any source starts or resumes the queue, and the stored result of
   // the last or a pausing command ends the scan. A pausing command that
   // is also the last one leaves the queue idle, not paused.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q1State_q <= Q1_IDLE;
      end else begin
         case (q1State_q)
            Q1_IDLE, Q1_PAUSED: begin
               if (q1Trigger) begin
                  q1State_q <= Q1_ACTIVE;
               end
            end
            Q1_ACTIVE: begin
               // Extra triggers here never disturb execution
               if (resultStored && !resultQueue2 && lastQ1) begin
                  q1State_q <= Q1_IDLE;
               end else if (resultStored && !resultQueue2 && commandPause) begin
                  q1State_q <= Q1_PAUSED;
               end
            end
            default: q1State_q <= Q1_IDLE;
         endcase
      end
   end

   //------------------------------------------------------------
   // Control registers
   //------------------------------------------------------------
   // Interrupt enables
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqEnable_q <= `RST_IRQ_ENABLE;
      end else if (wrStrobe && byteenable[0] && accIrqEnable) begin
         irqEnable_q <= writedata[3:0];
      end
   end

   // Queue-2 start pointer; queue 1 sees a new value on its next result
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q2Start_q <= `RST_Q2_START;
      end else if (wrStrobe && byteenable[0] && accQ2Start) begin
         q2Start_q <= writedata[5:0];  // Takes effect at once for queue 1
      end
   end

   //------------------------------------------------------------
   // Read data, registered; read-only fields come straight from inputs
   //------------------------------------------------------------
   // Read multiplexer; no write path reaches the read-only fields
   always_comb begin
      readMux = 32'h0000_0000;
      case (address)
         `OFS_STATUS:     readMux = {16'h0000, flags_q, queueStatus, commandPointer};
         `OFS_IRQ_ENABLE: readMux = {28'h0000000, irqEnable_q};
         `OFS_Q2_START:   readMux = {26'h0000000, q2Start_q};
         default:         readMux = 32'h0000_0000;
      endcase
   end

   // Loaded on the first edge of a read, so it stands at the accepting edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readdata <= 32'h0000_0000;
      end else if (read && !busPhase_q) begin
         readdata <= readMux;
      end
   end

   //------------------------------------------------------------
   // Interrupt requests, level encoding done outside
   //------------------------------------------------------------
   // Requests are levels: they follow the flags one cycle late and fall
   // one cycle after the acknowledging write or a disabling write.

   // Queue-1 request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q1IrqRequest <= 1'b0;
      end else begin
         q1IrqRequest <= (flags_q[5] & irqEnable_q[`EN_Q1_DONE])
                       | (flags_q[4] & irqEnable_q[`EN_Q1_PAUSE]);
      end
   end

   // Queue-2 request
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q2IrqRequest <= 1'b0;
      end else begin
         q2IrqRequest <= (flags_q[3] & irqEnable_q[`EN_Q2_DONE])
                       | (flags_q[2] & irqEnable_q[`EN_Q2_PAUSE]);
      end
   end

   // Queue-1 end pulse, one cycle per ending result
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q1Ended <= 1'b0;
      end else begin
         q1Ended <= resultStored & ~resultQueue2 & lastQ1;
      end
   end

   // Queue-2 end pulse, one cycle per ending result
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q2Ended <= 1'b0;
      end else begin
         q2Ended <= resultStored & resultQueue2 & lastQ2;
      end
   end

endmodule // adc_queue_status_flags

`default_nettype wire

// ==== testbench/adc_engine_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// Engine model: one stored result per go pulse
module adc_engine_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic       q2,
   input  wire logic [5:0] loc,
   input  wire logic [5:0] chan,
   input  wire logic       pause,
   output logic            resultStored,
   output logic            resultQueue2,
   output logic [5:0]      commandLocation,
   output logic [5:0]      commandChannel,
   output logic            commandPause
);
   // Fields only qualify the pulse; inverted between pulses so stale values never match
   always_ff @(posedge clk) begin
      resultStored    <= go;
      resultQueue2    <= go ? q2 : !q2;
      commandLocation <= go ? loc : ~loc;
      commandChannel  <= go ? chan : ~chan;
      commandPause    <= go ? pause : !pause;
   end
endmodule // adc_engine_model
`default_nettype wire

// ==== testbench/adc_flags_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module adc_flags_monitor (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       read,
   input wire logic       write,
   input wire logic       waitrequest,
   input wire logic       resultStored,
   input wire logic       resultQueue2,
   input wire logic [5:0] commandLocation,
   input wire logic [5:0] commandChannel,
   input wire logic       q1IrqRequest,
   input wire logic       q2IrqRequest,
   input wire logic       q1Ended,
   input wire logic       q2Ended
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Each new request sees exactly one wait cycle
   sequence s_req; $rose(read | write); endsequence
   sequence s_wait; waitrequest ##1 !waitrequest; endsequence
   property p_wait; s_req |-> s_wait; endproperty
   property p_q1eoq; resultStored && !resultQueue2 && commandChannel == 6'd63 |=> q1Ended; endproperty
   property p_q2last; resultStored && resultQueue2 && commandLocation == 6'd39 |=> q2Ended; endproperty
   property p_q2more;
      resultStored && resultQueue2 && commandChannel != 6'd63 && commandLocation != 6'd39
      |=> !q2Ended;
   endproperty
   property p_q2only; resultStored && resultQueue2 |=> !q1Ended; endproperty
   // Requests drop only after a bus write clears a flag or an enable
   property p_q1fall; $fell(q1IrqRequest) |-> $past(write) || $past(write, 2); endproperty
   property p_q2fall; $fell(q2IrqRequest) |-> $past(write) || $past(write, 2); endproperty
   property p_q1rise;
      $rose(q1IrqRequest) |-> $past(resultStored) || $past(resultStored, 2)
                              || $past(write) || $past(write, 2);
   endproperty
   a_wait: assert property (p_wait) else $error("wait cycle count wrong");
   a_q1eoq: assert property (p_q1eoq) else $error("queue 1 end code missed");
   a_q2last: assert property (p_q2last) else $error("queue 2 last location missed");
   a_q2more: assert property (p_q2more) else $error("queue 2 ended early");
   a_q2only: assert property (p_q2only) else $error("queue 1 ended by queue 2");
   a_q1fall: assert property (p_q1fall) else $error("queue 1 request dropped");
   a_q2fall: assert property (p_q2fall) else $error("queue 2 request dropped");
   a_q1rise: assert property (p_q1rise) else $error("queue 1 request uncaused");
endmodule // adc_flags_monitor
bind adc_queue_status_flags adc_flags_monitor mon_u (.clk(clk), .rst(rst), .read(read),
   .write(write), .waitrequest(waitrequest), .resultStored(resultStored),
   .resultQueue2(resultQueue2), .commandLocation(commandLocation),
   .commandChannel(commandChannel), .q1IrqRequest(q1IrqRequest),
   .q2IrqRequest(q2IrqRequest), .q1Ended(q1Ended), .q2Ended(q2Ended));
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import adc_flags_pkg::*;
   logic clk, rst, read, write, go, q2, pause, q1Trigger, q1TriggerHardware, waitrequest;
   logic rs, rq, cp, q1IrqRequest, q2IrqRequest, q1Ended, q2Ended;
   logic [3:0] address;
   logic [5:0] loc, chan, cl, cc;
   logic [31:0] writedata, readdata;
   int mismatches, total_checks;
   adc_engine_model eng_u (.clk(clk), .go(go), .q2(q2), .loc(loc), .chan(chan), .pause(pause),
      .resultStored(rs), .resultQueue2(rq), .commandLocation(cl), .commandChannel(cc),
      .commandPause(cp));
   adc_queue_status_flags dut_u (.clk(clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
      .waitrequest(waitrequest), .resultStored(rs), .resultQueue2(rq), .commandLocation(cl),
      .commandChannel(cc), .commandPause(cp), .q1Trigger(q1Trigger),
      .q1TriggerHardware(q1TriggerHardware), .queueStatus(4'hA), .commandPointer(6'h15),
      .q1IrqRequest(q1IrqRequest), .q2IrqRequest(q2IrqRequest), .q1Ended(q1Ended),
      .q2Ended(q2Ended));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // Request held until the rising edge at which waitrequest is sampled low
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] v);
      int n;
      n = 0;
      @(posedge clk);
      read      <= !w;
      write     <= w;
      address   <= a;
      writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) begin
         mismatches++;
         $display("mismatch waitrequest expected 0 seen %b", waitrequest);
      end
      v = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] v;
      bus(1'b0, a, 32'h0, v);
      check("readdata", v, e);
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] v;
      bus(1'b1, a, d, v);
   endtask
   task automatic store(input logic q, input logic [5:0] l, input logic [5:0] c, input logic p);
      @(posedge clk);
      {go, q2, loc, chan, pause} <= {1'b1, q, l, c, p};
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic trig(input logic hw);
      @(posedge clk);
      q1Trigger         <= 1'b1;
      q1TriggerHardware <= hw;
      @(posedge clk);
      q1Trigger <= 1'b0;
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs;
      wr(4'h0, 32'h0000_03FF);
      rd(4'h0, 32'h0000_0295);
      rd(4'h4, 32'h0);
      rd(4'h8, 32'h28);
      rd(4'hC, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_q1done;
      store(1'b0, 6'h05, 6'd63, 1'b0);
      wr(4'h0, 32'h0);
      check("q1IrqRequest", q1IrqRequest, 1'b0);
      rd(4'h0, 32'h0000_8295);
      wr(4'h0, 32'h0);
      rd(4'h0, 32'h0000_0295);
      $display("test q1done done");
   endtask
   task automatic t_pause;
      wr(4'h4, 32'h8);
      store(1'b1, 6'd39, 6'h03, 1'b1);
      check("q2IrqRequest", q2IrqRequest, 1'b1);
      rd(4'h0, 32'h0000_3295);
      wr(4'h0, 32'h0);
      repeat (2) @(posedge clk);
      check("q2IrqRequest", q2IrqRequest, 1'b0);
      wr(4'h4, 32'h2);
      store(1'b0, 6'h03, 6'h03, 1'b1);
      check("q1IrqRequest", q1IrqRequest, 1'b1);
      rd(4'h0, 32'h0000_4295);
      wr(4'h0, 32'h0);
      repeat (2) @(posedge clk);
      check("q1IrqRequest", q1IrqRequest, 1'b0);
      wr(4'h4, 32'h0);
      check("q1IrqRequest", q1IrqRequest, 1'b0);
      $display("test pause done");
   endtask
   task automatic t_start;
      wr(4'h8, 32'h0A);
      store(1'b0, 6'h09, 6'h03, 1'b0);
      store(1'b1, 6'h09, 6'h03, 1'b0);
      rd(4'h0, 32'h0000_8295);
      wr(4'h0, 32'h0);
      wr(4'h8, 32'h28);
      $display("test start done");
   endtask
   task automatic t_ovr;
      trig(1'b0);
      trig(1'b0);
      store(1'b0, 6'h02, 6'd63, 1'b0);
      rd(4'h0, 32'h0000_8295);
      wr(4'h0, 32'h0);
      trig(1'b1);
      rd(4'h0, 32'h0000_0295);
      trig(1'b1);
      store(1'b0, 6'h02, 6'd63, 1'b0);
      rd(4'h0, 32'h0000_8A95);
      wr(4'h0, 32'h0);
      rd(4'h0, 32'h0000_0295);
      $display("test ovr done");
   endtask
   // Clock, watchdog and main sequence
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      #200000;
      mismatches++;
      wrap_up();
   end
   initial begin
      {rst, read, write, go, q2, pause, q1Trigger, q1TriggerHardware} = 8'hFF & 8'h80;
      {address, loc, chan, writedata} = '0;
      mismatches = 0;
      total_checks = 0;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_q1done();
      t_pause();
      t_start();
      t_ovr();
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire
